/* File: shared/srb_params.svh */
// srb_params.svh: constants for the short relative branch unit
// assumes inclusion by bare name from design files
`ifndef SRB_PARAMS_SVH
`define SRB_PARAMS_SVH
`define SRB_PREFIX 4'hC
`define SRB_PREFIX_HI 15
`define SRB_PREFIX_LO 12
`define SRB_COND_HI 11
`define SRB_COND_LO 8
`define SRB_DISP_HI 7
`define SRB_DISP_LO 0
`define SRB_WORD_BITS 32'h00000010
`define SRB_WORD_SHIFT 4
`define SRB_PC_RESET 32'h00000000
`define SRB_ALIGN_MASK 32'hFFFFFFF0
`endif

/* File: shared/srb_pkg.sv */
// srb_pkg.sv: types for the short relative branch unit
// assumes nothing of its surroundings
package srb_pkg;
    typedef logic [3:0] srb_cond_t;
    typedef enum logic [3:0] {
        SRB_ALWAYS = 4'h0,
        SRB_POSITIVE = 4'h1,
        SRB_LOWER_OR_SAME = 4'h2,
        SRB_HIGHER = 4'h3,
        SRB_SIGNED_LESS = 4'h4,
        SRB_SIGNED_GREATER_EQUAL = 4'h5,
        SRB_SIGNED_LESS_EQUAL = 4'h6,
        SRB_SIGNED_GREATER = 4'h7,
        SRB_ON_CARRY = 4'h8,
        SRB_ON_NO_CARRY = 4'h9,
        SRB_ON_ZERO = 4'hA,
        SRB_ON_NONZERO = 4'hB,
        SRB_ON_OVERFLOW = 4'hC,
        SRB_ON_NO_OVERFLOW = 4'hD,
        SRB_ON_NEGATIVE = 4'hE,
        SRB_ON_NONNEGATIVE = 4'hF
    } srb_sel_e;
    typedef enum logic [1:0] {
        SRB_ST_IDLE = 2'b01,
        SRB_ST_DONE = 2'b10
    } srb_state_e;
endpackage : srb_pkg

/* File: shared/srb_cond_if.sv */
// srb_cond_if.sv: condition test request and answer between top and evaluator
// assumes one clock; evaluator answers combinationally
`timescale 1ns/1ns
interface srb_cond_if;
    logic [3:0] sel;
    logic negFlag;
    logic carryFlag;
    logic zeroFlag;
    logic ovfFlag;
    logic take;
    modport top (output sel, output negFlag, output carryFlag, output zeroFlag, output ovfFlag, input take);
    modport eval (input sel, input negFlag, input carryFlag, input zeroFlag, input ovfFlag, output take);
endinterface : srb_cond_if

/* File: hdl/srb_cond_eval.sv */
// srb_cond_eval.sv: condition selector test against the N C Z V flags
// assumes flags are stable while sel is applied
`timescale 1ns/1ns
module srb_cond_eval (
    srb_cond_if.eval cif
);
    logic n;
    logic c;
    logic z;
    logic v;
    assign n = cif.negFlag;
    assign c = cif.carryFlag;
    assign z = cif.zeroFlag;
    assign v = cif.ovfFlag;

    // each multi-term condition except positive and higher is an or of alternatives; those two are ands
    always_comb begin
        unique case (srb_pkg::srb_sel_e'(cif.sel))
            srb_pkg::SRB_ALWAYS: cif.take = 1'b1;
            srb_pkg::SRB_POSITIVE: cif.take = !n && !z;
            srb_pkg::SRB_LOWER_OR_SAME: cif.take = c || z;
            srb_pkg::SRB_HIGHER: cif.take = !c && !z;
            srb_pkg::SRB_SIGNED_LESS: cif.take = (n && !v) || (!n && v);
            srb_pkg::SRB_SIGNED_GREATER_EQUAL: cif.take = (n && v) || (!n && !v);
            srb_pkg::SRB_SIGNED_LESS_EQUAL: cif.take = (n && !v) || (!n && v) || z;
            srb_pkg::SRB_SIGNED_GREATER: cif.take = (n && v && !z) || (!n && !v && !z);
            srb_pkg::SRB_ON_CARRY: cif.take = c;
            srb_pkg::SRB_ON_NO_CARRY: cif.take = !c;
            srb_pkg::SRB_ON_ZERO: cif.take = z;
            srb_pkg::SRB_ON_NONZERO: cif.take = !z;
            srb_pkg::SRB_ON_OVERFLOW: cif.take = v;
            srb_pkg::SRB_ON_NO_OVERFLOW: cif.take = !v;
            srb_pkg::SRB_ON_NEGATIVE: cif.take = n;
            srb_pkg::SRB_ON_NONNEGATIVE: cif.take = !n;
        endcase
    end
endmodule : srb_cond_eval

/* File: hdl/short_relative_branch_unit.sv */
// short_relative_branch_unit.sv: executes the one-word short relative conditional branch
// assumes opcodes arrive with a one-cycle valid strobe and flags stable in that cycle
// Behaviour
// - condition from bits 11..8, displacement from low byte, prefix 1100 required
// - condition true: pc becomes next address plus signed word displacement
// - condition false: pc becomes next sequential instruction address
// - low four bits of the program counter always stay zero
// - branch target is a full 32-bit address relative to next address
// - 0000 always, 0010 carry or zero, 0011 carry and zero clear
// - signed tests: 0100, 0110, 0101, 0111 from negative, overflow and zero
// - 1000 carry, 1001 no carry, 1010 zero, 1011 nonzero
// - 0001 positive, 1110/1111 negative, 1100/1101 overflow
// - status flags leave the unit exactly as they came in
// - multi-term conditions except 0001 and 0011 branch when any alternative matches
`timescale 1ns/1ns
`include "srb_params.svh"
module short_relative_branch_unit #(
    parameter int PC_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic opValid,
    input wire logic [15:0] opcode,
    input wire logic [PC_W-1:0] curPc,
    input wire logic [3:0] flagsIn,
    output logic [PC_W-1:0] pcOut,
    output logic pcValid,
    output logic branchTaken,
    output logic notBranch,
    output logic [3:0] flagsOut,
    output logic operandFetch
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    srb_cond_if cif ();
    srb_cond_eval u_eval (
        .cif(cif)
    );
    logic isBranch;
    logic [7:0] dispByte;
    logic [PC_W-1:0] nextAddr;
    logic [PC_W-1:0] dispOff;
    logic [PC_W-1:0] targetAddr;
    assign isBranch = opcode[`SRB_PREFIX_HI:`SRB_PREFIX_LO] == `SRB_PREFIX;
    assign dispByte = opcode[`SRB_DISP_HI:`SRB_DISP_LO];
    assign cif.sel = opcode[`SRB_COND_HI:`SRB_COND_LO];
    // flags ordered N C Z V from bit 3 down
    assign cif.negFlag = flagsIn[3];
    assign cif.carryFlag = flagsIn[2];
    assign cif.zeroFlag = flagsIn[1];
    assign cif.ovfFlag = flagsIn[0];
    assign nextAddr = PC_W'(curPc + PC_W'(`SRB_WORD_BITS));
    assign dispOff = PC_W'({{(PC_W-8){dispByte[7]}}, dispByte} <<< `SRB_WORD_SHIFT);
    assign targetAddr = PC_W'(nextAddr + dispOff);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    srb_pkg::srb_state_e state_q, state_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic taken_q, taken_d;
    logic nt_q, nt_d;
    logic [3:0] flags_q, flags_d;
    logic fetch_q, fetch_d;

    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        taken_d = 1'b0;
        nt_d = 1'b0;
        flags_d = flags_q;
        // one-word form never asks for an extension word
        fetch_d = 1'b0;
        unique case (state_q)
            srb_pkg::SRB_ST_IDLE: begin
                if (opValid && isBranch) begin
                    state_d = srb_pkg::SRB_ST_DONE;
                    flags_d = flagsIn;
                    if (cif.take) begin
                        pc_d = targetAddr & PC_W'(`SRB_ALIGN_MASK);
                        taken_d = 1'b1;
                    end else begin
                        pc_d = nextAddr & PC_W'(`SRB_ALIGN_MASK);
                        nt_d = 1'b1;
                    end
                end
            end
            srb_pkg::SRB_ST_DONE: begin
                // single word: completes without an operand fetch
                state_d = srb_pkg::SRB_ST_IDLE;
            end
            default: state_d = srb_pkg::SRB_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= srb_pkg::SRB_ST_IDLE;
            pc_q <= PC_W'(`SRB_PC_RESET);
            taken_q <= 1'b0;
            nt_q <= 1'b0;
            flags_q <= 4'h0;
            fetch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            taken_q <= taken_d;
            nt_q <= nt_d;
            flags_q <= flags_d;
            fetch_q <= fetch_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pcOut = pc_q;
    assign branchTaken = taken_q;
    assign notBranch = nt_q;
    // done is one-hot bit 1, so the pulse comes straight off the state flop
    assign pcValid = state_q[1];
    assign flagsOut = flags_q;
    assign operandFetch = fetch_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // accepted only while idle; a strobe in the done cycle is dropped
    sequence s_req_take;
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && isBranch && cif.take;
    endsequence
    sequence s_req_fall;
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && isBranch && !cif.take;
    endsequence

    property p_taken_target;
        @(posedge sys_clk) disable iff (!rst_n)
        s_req_take |=> branchTaken && pcValid
            && pcOut == PC_W'($past(curPc) + PC_W'(`SRB_WORD_BITS)
            + (PC_W'({{(PC_W-8){$past(dispByte[7])}}, $past(dispByte)}) << `SRB_WORD_SHIFT));
    endproperty
    a_taken_target: assert property (p_taken_target) else $error("taken target wrong");

    property p_fall_through;
        @(posedge sys_clk) disable iff (!rst_n)
        s_req_fall |=> notBranch && !branchTaken && pcValid
            && pcOut == PC_W'($past(curPc) + PC_W'(`SRB_WORD_BITS));
    endproperty
    a_fall_through: assert property (p_fall_through) else $error("fall through wrong");

    property p_align;
        @(posedge sys_clk) disable iff (!rst_n)
        pcOut[3:0] == 4'h0;
    endproperty
    a_align: assert property (p_align) else $error("pc not word aligned");

    property p_prefix;
        @(posedge sys_clk) disable iff (!rst_n)
        opValid && !isBranch |=> !branchTaken && !notBranch;
    endproperty
    a_prefix: assert property (p_prefix) else $error("non branch opcode executed");

    property p_flags;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && isBranch |=> flagsOut == $past(flagsIn);
    endproperty
    a_flags: assert property (p_flags) else $error("flags altered");

    property p_always;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && opcode[15:8] == 8'hC0 |=> branchTaken;
    endproperty
    a_always: assert property (p_always) else $error("always branch not taken");

    property p_signed_lt;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && opcode[15:8] == 8'hC4
            |=> branchTaken == ($past(flagsIn[3]) ^ $past(flagsIn[0]));
    endproperty
    a_signed_lt: assert property (p_signed_lt) else $error("signed less wrong");

    property p_zero_test;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && opcode[15:8] == 8'hCA
            |=> branchTaken == $past(flagsIn[1]);
    endproperty
    a_zero_test: assert property (p_zero_test) else $error("zero test wrong");

    property p_overflow;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && opcode[15:8] == 8'hCD
            |=> branchTaken == !$past(flagsIn[0]);
    endproperty
    a_overflow: assert property (p_overflow) else $error("no overflow test wrong");

    property p_lower_same;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && opcode[15:8] == 8'hC2
            |=> branchTaken == ($past(flagsIn[2]) || $past(flagsIn[1]));
    endproperty
    a_lower_same: assert property (p_lower_same) else $error("lower or same wrong");

    property p_positive;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == srb_pkg::SRB_ST_IDLE) && opValid && opcode[15:8] == 8'hC1
            |=> branchTaken == (!$past(flagsIn[3]) && !$past(flagsIn[1]));
    endproperty
    a_positive: assert property (p_positive) else $error("positive test wrong");

    // pc may only move on an accepted branch, which always raises pcValid
    property p_pc_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !pcValid |-> $stable(pcOut);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved without branch");

    property p_one_word;
        @(posedge sys_clk) disable iff (!rst_n)
        pcValid |=> !pcValid ##0 !operandFetch;
    endproperty
    a_one_word: assert property (p_one_word) else $error("extra cycle or fetch");
endmodule : short_relative_branch_unit

/* File: verification/tb_short_relative_branch_unit.sv */
// tb_short_relative_branch_unit.sv: self-checking bench for the short relative branch unit
// assumes the unit answers one edge after an accepted opcode and is busy for that one cycle
`timescale 1ns/1ns
module tb_short_relative_branch_unit;
    typedef struct packed {
        logic [31:0] pc;
        logic taken;
        logic [3:0] flags;
    } srb_exp_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic opValid = 1'b0;
    logic [15:0] opcode = 16'h0000;
    logic [31:0] curPc = 32'h00000000;
    logic [3:0] flagsIn = 4'h0;
    logic [31:0] pcOut;
    logic pcValid;
    logic branchTaken;
    logic notBranch;
    logic [3:0] flagsOut;
    logic operandFetch;
    srb_exp_s expQ[$];
    srb_exp_s expNow;
    logic [7:0] dispTab[6] = '{8'h7F, 8'h81, 8'h80, 8'h01, 8'hFF, 8'h00};
    // stands for a no-op or long-form word; value arbitrary, prefix is not the branch prefix
    localparam logic [15:0] OTHER_WORD = 16'h0000;
    logic [15:0] op;
    int errCount = 0;
    int cmpCount = 0;
    int cycles = 0;

    always #20 sys_clk = ~sys_clk;

    short_relative_branch_unit #(.PC_W(32)) u_short_relative_branch_unit (
        .sys_clk(sys_clk), .rst_n(rst_n), .opValid(opValid), .opcode(opcode), .curPc(curPc),
        .flagsIn(flagsIn), .pcOut(pcOut), .pcValid(pcValid), .branchTaken(branchTaken),
        .notBranch(notBranch), .flagsOut(flagsOut), .operandFetch(operandFetch)
    );

    // ----------------------------------------
    // reference and compare helpers
    // ----------------------------------------
    function automatic logic cond_true(input logic [3:0] sel, input logic [3:0] f);
        logic n, c, z, v;
        {n, c, z, v} = f;
        case (sel)
            4'h0: return 1'b1;
            4'h1: return !n && !z;
            4'h2: return c || z;
            4'h3: return !c && !z;
            4'h4: return n ^ v;
            4'h5: return !(n ^ v);
            4'h6: return (n ^ v) || z;
            4'h7: return !(n ^ v) && !z;
            4'h8: return c;
            4'h9: return !c;
            4'hA: return z;
            4'hB: return !z;
            4'hC: return v;
            4'hD: return !v;
            4'hE: return n;
            default: return !n;
        endcase
    endfunction : cond_true

    function automatic logic [31:0] exp_pc(input logic [15:0] o, input logic [31:0] pc, input logic [3:0] f);
        logic [31:0] nxt;
        nxt = pc + 32'h00000010;
        if (cond_true(o[11:8], f)) nxt = nxt + {{20{o[7]}}, o[7:0], 4'h0};
        return nxt & 32'hFFFFFFF0;
    endfunction : exp_pc

    // generator side: short form only for -127..127 words, never zero
    function automatic logic [15:0] gen_word(input logic [3:0] sel, input logic [7:0] disp);
        if (disp == 8'h00 || disp == 8'h80) return OTHER_WORD;
        return {4'hC, sel, disp};
    endfunction : gen_word

    task automatic chk_pc(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_pc

    task automatic chk_small(input logic [3:0] got, input logic [3:0] exp, input string what);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_small

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    // inputs scrambled after the strobe so late capture of flags or pc shows up
    task automatic issue(input logic [15:0] o, input logic [31:0] pc, input logic [3:0] f);
        @(negedge sys_clk);
        opValid = 1'b1;
        opcode = o;
        curPc = pc;
        flagsIn = f;
        if (o[15:12] === 4'hC) expQ.push_back('{exp_pc(o, pc, f), cond_true(o[11:8], f), f});
        @(negedge sys_clk);
        opValid = 1'b0;
        opcode = 16'($urandom);
        curPc = $urandom;
        flagsIn = 4'($urandom);
    endtask : issue

    // ----------------------------------------
    // output watcher and hang guard
    // ----------------------------------------
    always @(posedge sys_clk) begin
        #1;
        if (rst_n === 1'b1) begin
            chk_small({3'b000, operandFetch}, 4'h0, "operand fetch");
            chk_small(pcOut[3:0], 4'h0, "pc alignment");
            if (pcValid === 1'b1) begin
                if (expQ.size() == 0) begin
                    errCount++;
                    $display("CHECK FAILED at %0t: unexpected result", $time);
                end else begin
                    expNow = expQ.pop_front();
                    chk_pc(pcOut, expNow.pc, "pc");
                    chk_small({2'b00, branchTaken, notBranch}, {2'b00, expNow.taken, ~expNow.taken}, "outcome");
                    chk_small(flagsOut, expNow.flags, "flags");
                end
            end else begin
                chk_small({2'b00, branchTaken, notBranch}, 4'h0, "idle pulses");
            end
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            $display("CHECK FAILED at %0t: timeout", $time);
            final_report();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(16772));
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        for (int s = 0; s < 16; s++) begin
            for (int f = 0; f < 16; f++) begin
                issue(gen_word(s[3:0], 8'($urandom)), $urandom & 32'hFFFFFFF0, f[3:0]);
            end
        end
        $display("test selector sweep done");
        foreach (dispTab[i]) begin
            issue(gen_word(4'h0, dispTab[i]), 32'hFFFFFFF0, 4'($urandom));
            issue(gen_word(4'h0, dispTab[i]), 32'h00000000, 4'($urandom));
        end
        $display("test displacement bounds done");
        repeat (8) begin
            op = 16'($urandom);
            if (op[15:12] == 4'hC) op[15] = 1'b0;
            issue(op, $urandom & 32'hFFFFFFF0, 4'($urandom));
        end
        $display("test foreign prefix done");
        @(negedge sys_clk);
        opValid = 1'b1;
        opcode = 16'hC97F;
        curPc = 32'h00001000;
        flagsIn = 4'h0;
        expQ.push_back('{32'h00001800, 1'b1, 4'h0});
        @(negedge sys_clk);
        opcode = 16'hC001;
        flagsIn = 4'hF;
        @(negedge sys_clk);
        opValid = 1'b0;
        $display("test back to back done");
        issue(16'hC0FE, 32'h00000100, 4'hA);
        @(negedge sys_clk);
        rst_n = 1'b0;
        #1;
        chk_pc(pcOut, 32'h00000000, "pc in reset");
        chk_small(flagsOut, 4'h0, "flags in reset");
        @(negedge sys_clk);
        rst_n = 1'b1;
        issue(16'hCA05, 32'h00000200, 4'h0);
        repeat (3) @(posedge sys_clk);
        chk_small(4'(expQ.size()), 4'h0, "pending results");
        $display("test reset mid run done");
        final_report();
    end
endmodule : tb_short_relative_branch_unit
